// ==== rtl/mixer_gain_consts.vh ====
// register offsets, field positions, reset values and timing for the mixer gain bank
`ifndef MIXER_GAIN_CONSTS_VH
`define MIXER_GAIN_CONSTS_VH
`define AUX3_MIX_GAIN_IDX 4'h6
`define MIC_MIX_GAIN_IDX 4'h7
`define MONO_MISC_IDX 4'h8
`define AUX3_MIX_GAIN_ADDR 8'h18
`define MIC_MIX_GAIN_ADDR 8'h1C
`define MONO_MISC_ADDR 8'h20
`define PWR_CTRL_ADDR 8'h00
`define MIX_DEFAULT 16'h8888
`define MONO_MISC_DEFAULT 16'h8800
`define MIX_WMASK 16'h9F9F
`define MONO_MISC_WMASK 16'h9FFB
`define PWR_CTRL_WMASK 16'h0007
`define LEFT_MUTE_BIT 15
`define LEFT_GAIN_MSB 12
`define LEFT_GAIN_LSB 8
`define RIGHT_MUTE_BIT 7
`define RIGHT_GAIN_MSB 4
`define RIGHT_GAIN_LSB 0
`define ALL_MIX_MUTE_BIT 7
`define MONO_OUT_MUTE_BIT 6
`define HP_OUT_MUTE_BIT 5
`define HP_SWING_BIT 4
`define SUM_PINS_MUTE_BIT 3
`define DAC2_TIMING_BIT 1
`define DAC1_TIMING_BIT 0
`define PWR_CONV_DOWN_BIT 0
`define PWR_MIX_EN_BIT 1
`define PWR_ANA_EN_BIT 2
`define GAIN_TIMEOUT_US 10000
`define CLK_MHZ 200
`define GAIN_TIMEOUT_CYCLES (`GAIN_TIMEOUT_US * `CLK_MHZ)
`endif

// ==== rtl/gain_change_timer.v ====
// deferred gain apply: immediate, on midscale crossing, or after a timeout
`include "mixer_gain_consts.vh"
module gain_change_timer #(
    parameter TIMEOUT_CYCLES = `GAIN_TIMEOUT_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire immediate,
    input wire [4:0] requested_gain,
    input wire midscale_cross,
    output reg [4:0] applied_gain
);
    reg [31:0] count_reg;
    reg pending_reg;
    always @(posedge clk) begin
        if (rst) begin
            applied_gain <= 5'h08;
            pending_reg <= 1'b0;
            count_reg <= 32'h0000_0000;
        end else if (immediate) begin
            applied_gain <= requested_gain;
            pending_reg <= 1'b0;
            count_reg <= 32'h0000_0000;
        end else if (requested_gain != applied_gain) begin
            if (midscale_cross || count_reg >= TIMEOUT_CYCLES - 1) begin
                applied_gain <= requested_gain;
                pending_reg <= 1'b0;
                count_reg <= 32'h0000_0000;
            end else begin
                pending_reg <= 1'b1;
                count_reg <= count_reg + 32'h0000_0001;
            end
        end else begin
            pending_reg <= 1'b0;
            count_reg <= 32'h0000_0000;
        end
    end
endmodule // gain_change_timer

// ==== rtl/mixer_gain_control_regs.v ====
// mixer gain and misc control register bank behind an axi4-lite slave
// Notes on behaviour
// - aux3 reg: left mute 15, left gain 12..8, right mute 7, right gain 4..0.
// - mic reg uses identical layout to aux3 reg.
// - path mute bit 0 enables path, 1 mutes it.
// - gain code 1.5 dB per step; 00000 +12, 01000 0, 11111 -34.5 dB.
// - aux3 and mic registers reset to 0x8888.
// - reset or powerdown pin low forces mix registers to default, blocks writes.
// - conversion power-down bit high holds mix registers at default.
// - mix-enable or analog-enable bit low holds mix registers at default.
// - mono input mute 0 passes mono input, 1 mutes it.
// - mono gain uses the same 1.5 dB step coding.
// - timing bit 1 applies dac gain now, 0 waits for midscale or timeout.
// - all-mix mute overrides every individual mix mute.
// - swing 0 gives 2 V p-p, 1 gives 4 V; other mutes 0 enable.
`include "mixer_gain_consts.vh"
module mixer_gain_control_regs #(
    parameter TIMEOUT_CYCLES = `GAIN_TIMEOUT_CYCLES
) (
    input wire CORE_CLK,
    input wire RST,
    input wire RESET_PIN_N,
    input wire POWERDOWN_PIN_N,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire DAC1_MIDSCALE_CROSS,
    input wire DAC2_MIDSCALE_CROSS,
    input wire [4:0] DAC1_GAIN_REQ,
    input wire [4:0] DAC2_GAIN_REQ,
    output reg [4:0] DAC1_GAIN_APPLIED,
    output reg [4:0] DAC2_GAIN_APPLIED,
    output reg LEFT_AUX3_MIX_ON,
    output reg RIGHT_AUX3_MIX_ON,
    output reg LEFT_MIC_MIX_ON,
    output reg RIGHT_MIC_MIX_ON,
    output reg MONO_IN_MIX_ON,
    output reg [4:0] LEFT_AUX3_MIX_GAIN,
    output reg [4:0] RIGHT_AUX3_MIX_GAIN,
    output reg [4:0] LEFT_MIC_MIX_GAIN,
    output reg [4:0] RIGHT_MIC_MIX_GAIN,
    output reg [4:0] MONO_IN_MIX_GAIN,
    output reg MONO_OUT_ON,
    output reg HEADPHONE_OUT_ON,
    output reg HEADPHONE_SWING_4V,
    output reg SUM_PINS_MIX_ON
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RESP = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg [2:0] wr_state_reg;
    reg [2:0] wr_state_next;
    reg aw_held_reg;
    reg w_held_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg [15:0] aux3_mix_gain_reg;
    reg [15:0] mic_mix_gain_reg;
    reg [15:0] mono_in_and_misc_ctrl_reg;
    reg [15:0] pwr_ctrl_reg;
    wire hold_default;
    wire [4:0] dac1_applied;
    wire [4:0] dac2_applied;
    wire wr_fire;
    wire [15:0] wr_value;
    wire aw_take;
    wire w_take;

    // merge a 16-bit word with byte lanes and a writable mask
    function [15:0] merge_word;
        input [15:0] old_value;
        input [31:0] data;
        input [3:0] strb;
        input [15:0] mask;
        reg [15:0] lane;
        begin
            lane = {{8{strb[1]}}, {8{strb[0]}}};
            merge_word = ((old_value & ~lane) | (data[15:0] & lane)) & mask;
        end
    endfunction

    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = (addr == `AUX3_MIX_GAIN_ADDR) || (addr == `MIC_MIX_GAIN_ADDR) ||
                (addr == `MONO_MISC_ADDR) || (addr == `PWR_CTRL_ADDR);
        end
    endfunction

    // default hold from pins and power bits
    assign hold_default = !RESET_PIN_N || !POWERDOWN_PIN_N ||
        pwr_ctrl_reg[`PWR_CONV_DOWN_BIT] ||
        !pwr_ctrl_reg[`PWR_MIX_EN_BIT] || !pwr_ctrl_reg[`PWR_ANA_EN_BIT];

    // write address and data taken in either order
    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID && S_AXI_WREADY;
    assign S_AXI_AWREADY = (wr_state_reg == ST_IDLE) && !aw_held_reg;
    assign S_AXI_WREADY = (wr_state_reg == ST_IDLE) && !w_held_reg;
    assign wr_fire = (wr_state_reg == ST_IDLE) && (aw_held_reg || aw_take) && (w_held_reg || w_take);
    assign wr_value = w_held_reg ? w_data_reg[15:0] : S_AXI_WDATA[15:0];

    always @* begin
        case (wr_state_reg)
            ST_IDLE: begin
                wr_state_next = wr_fire ? ST_RESP : ST_IDLE;
            end
            ST_RESP: begin
                wr_state_next = S_AXI_BREADY ? ST_IDLE : ST_WAIT;
            end
            ST_WAIT: begin
                wr_state_next = S_AXI_BREADY ? ST_IDLE : ST_WAIT;
            end
            default: begin
                wr_state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (RST) begin
            wr_state_reg <= ST_IDLE;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
        end else begin
            wr_state_reg <= wr_state_next;
            if (aw_take) begin
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= is_mapped(aw_held_reg ? aw_addr_reg : S_AXI_AWADDR) ? 2'b00 : 2'b10;
            end else begin
                if (aw_take) begin
                    aw_held_reg <= 1'b1;
                end
                if (w_take) begin
                    w_held_reg <= 1'b1;
                end
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
        end
    end

    // register storage
    always @(posedge CORE_CLK) begin : regs
        reg [7:0] a;
        reg [3:0] s;
        a = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR;
        s = w_held_reg ? w_strb_reg : S_AXI_WSTRB;
        if (RST) begin
            aux3_mix_gain_reg <= `MIX_DEFAULT;
            mic_mix_gain_reg <= `MIX_DEFAULT;
            mono_in_and_misc_ctrl_reg <= `MONO_MISC_DEFAULT;
            pwr_ctrl_reg <= 16'h0006;
        end else begin
            if (wr_fire && a == `PWR_CTRL_ADDR) begin
                pwr_ctrl_reg <= merge_word(pwr_ctrl_reg, {16'h0000, wr_value}, s, `PWR_CTRL_WMASK);
            end
            if (wr_fire && a == `MONO_MISC_ADDR) begin
                mono_in_and_misc_ctrl_reg <= merge_word(mono_in_and_misc_ctrl_reg, {16'h0000, wr_value}, s,
                    `MONO_MISC_WMASK);
            end
            if (hold_default) begin
                aux3_mix_gain_reg <= `MIX_DEFAULT;
                mic_mix_gain_reg <= `MIX_DEFAULT;
            end else if (wr_fire && a == `AUX3_MIX_GAIN_ADDR) begin
                aux3_mix_gain_reg <= merge_word(aux3_mix_gain_reg, {16'h0000, wr_value}, s, `MIX_WMASK);
            end else if (wr_fire && a == `MIC_MIX_GAIN_ADDR) begin
                mic_mix_gain_reg <= merge_word(mic_mix_gain_reg, {16'h0000, wr_value}, s, `MIX_WMASK);
            end
        end
    end

    // read channel: one cycle after address taken
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always @(posedge CORE_CLK) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b00;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
            case (S_AXI_ARADDR)
                `AUX3_MIX_GAIN_ADDR: S_AXI_RDATA <= {16'h0000, hold_default ? `MIX_DEFAULT : aux3_mix_gain_reg};
                `MIC_MIX_GAIN_ADDR: S_AXI_RDATA <= {16'h0000, hold_default ? `MIX_DEFAULT : mic_mix_gain_reg};
                `MONO_MISC_ADDR: S_AXI_RDATA <= {16'h0000, mono_in_and_misc_ctrl_reg};
                `PWR_CTRL_ADDR: S_AXI_RDATA <= {16'h0000, pwr_ctrl_reg};
                default: S_AXI_RDATA <= 32'h0000_0000;
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // dac gain change timing
    gain_change_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_dac1_timer (
        .clk(CORE_CLK),
        .rst(RST),
        .immediate(mono_in_and_misc_ctrl_reg[`DAC1_TIMING_BIT]),
        .requested_gain(DAC1_GAIN_REQ),
        .midscale_cross(DAC1_MIDSCALE_CROSS),
        .applied_gain(dac1_applied)
    );
    gain_change_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_dac2_timer (
        .clk(CORE_CLK),
        .rst(RST),
        .immediate(mono_in_and_misc_ctrl_reg[`DAC2_TIMING_BIT]),
        .requested_gain(DAC2_GAIN_REQ),
        .midscale_cross(DAC2_MIDSCALE_CROSS),
        .applied_gain(dac2_applied)
    );

    // registered mixer control outputs
    always @(posedge CORE_CLK) begin : outs
        reg all_off;
        all_off = mono_in_and_misc_ctrl_reg[`ALL_MIX_MUTE_BIT];
        if (RST) begin
            LEFT_AUX3_MIX_ON <= 1'b0;
            RIGHT_AUX3_MIX_ON <= 1'b0;
            LEFT_MIC_MIX_ON <= 1'b0;
            RIGHT_MIC_MIX_ON <= 1'b0;
            MONO_IN_MIX_ON <= 1'b0;
            LEFT_AUX3_MIX_GAIN <= 5'h08;
            RIGHT_AUX3_MIX_GAIN <= 5'h08;
            LEFT_MIC_MIX_GAIN <= 5'h08;
            RIGHT_MIC_MIX_GAIN <= 5'h08;
            MONO_IN_MIX_GAIN <= 5'h08;
            MONO_OUT_ON <= 1'b1;
            HEADPHONE_OUT_ON <= 1'b1;
            HEADPHONE_SWING_4V <= 1'b0;
            SUM_PINS_MIX_ON <= 1'b0;
            DAC1_GAIN_APPLIED <= 5'h08;
            DAC2_GAIN_APPLIED <= 5'h08;
        end else begin
            LEFT_AUX3_MIX_ON <= !aux3_mix_gain_reg[`LEFT_MUTE_BIT] && !all_off;
            RIGHT_AUX3_MIX_ON <= !aux3_mix_gain_reg[`RIGHT_MUTE_BIT] && !all_off;
            LEFT_MIC_MIX_ON <= !mic_mix_gain_reg[`LEFT_MUTE_BIT] && !all_off;
            RIGHT_MIC_MIX_ON <= !mic_mix_gain_reg[`RIGHT_MUTE_BIT] && !all_off;
            MONO_IN_MIX_ON <= !mono_in_and_misc_ctrl_reg[`LEFT_MUTE_BIT] && !all_off;
            LEFT_AUX3_MIX_GAIN <= aux3_mix_gain_reg[`LEFT_GAIN_MSB:`LEFT_GAIN_LSB];
            RIGHT_AUX3_MIX_GAIN <= aux3_mix_gain_reg[`RIGHT_GAIN_MSB:`RIGHT_GAIN_LSB];
            LEFT_MIC_MIX_GAIN <= mic_mix_gain_reg[`LEFT_GAIN_MSB:`LEFT_GAIN_LSB];
            RIGHT_MIC_MIX_GAIN <= mic_mix_gain_reg[`RIGHT_GAIN_MSB:`RIGHT_GAIN_LSB];
            MONO_IN_MIX_GAIN <= mono_in_and_misc_ctrl_reg[`LEFT_GAIN_MSB:`LEFT_GAIN_LSB];
            MONO_OUT_ON <= !mono_in_and_misc_ctrl_reg[`MONO_OUT_MUTE_BIT];
            HEADPHONE_OUT_ON <= !mono_in_and_misc_ctrl_reg[`HP_OUT_MUTE_BIT];
            HEADPHONE_SWING_4V <= mono_in_and_misc_ctrl_reg[`HP_SWING_BIT];
            SUM_PINS_MIX_ON <= !mono_in_and_misc_ctrl_reg[`SUM_PINS_MUTE_BIT] && !all_off;
            DAC1_GAIN_APPLIED <= dac1_applied;
            DAC2_GAIN_APPLIED <= dac2_applied;
        end
    end
endmodule // mixer_gain_control_regs

// ==== testbench/mixer_gain_control_regs_checker.sv ====
// assertion checker for the mixer gain register bank
module mixer_gain_control_regs_checker (
    input logic CORE_CLK, RST, RESET_PIN_N, POWERDOWN_PIN_N,
    input logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR,
    input logic S_AXI_ARVALID, S_AXI_ARREADY,
    input logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_RVALID,
    input logic [31:0] S_AXI_WDATA, S_AXI_RDATA,
    input logic [3:0] S_AXI_WSTRB,
    input logic LEFT_AUX3_MIX_ON, LEFT_MIC_MIX_ON, MONO_IN_MIX_ON, SUM_PINS_MIX_ON,
    input logic MONO_OUT_ON, HEADPHONE_OUT_ON, HEADPHONE_SWING_4V,
    input logic [4:0] LEFT_AUX3_MIX_GAIN, RIGHT_AUX3_MIX_GAIN, LEFT_MIC_MIX_GAIN, MONO_IN_MIX_GAIN
);
    logic [2:0] pwr_reg;
    logic all_mute_reg;
    logic [47:0] wd_reg;
    logic [7:0] ar_reg;
    wire take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    wire hold = !RESET_PIN_N || !POWERDOWN_PIN_N || pwr_reg != 3'h6;
    wire [15:0] w3 = wd_reg[47:32];
    // tracks power control and all-mix mute as written
    always_ff @(posedge CORE_CLK) begin
        wd_reg <= {wd_reg[31:0], S_AXI_WDATA[15:0]};
        if (S_AXI_ARVALID && S_AXI_ARREADY) ar_reg <= S_AXI_ARADDR;
        if (RST) begin
            pwr_reg <= 3'h6;
            all_mute_reg <= 1'h0;
        end else if (take && S_AXI_WSTRB[0]) begin
            if (S_AXI_AWADDR == 8'h00) pwr_reg <= S_AXI_WDATA[2:0];
            if (S_AXI_AWADDR == 8'h20) all_mute_reg <= S_AXI_WDATA[7];
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_reset_default;
        disable iff (1'h0) RST ##1 RST |-> ##1 LEFT_AUX3_MIX_GAIN == 5'h08 && MONO_IN_MIX_GAIN == 5'h08
            && !LEFT_AUX3_MIX_ON && MONO_OUT_ON && !HEADPHONE_SWING_4V;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset defaults missing");
    property p_hold_default;
        hold [*4] |-> LEFT_AUX3_MIX_GAIN == 5'h08 && RIGHT_AUX3_MIX_GAIN == 5'h08
            && LEFT_MIC_MIX_GAIN == 5'h08 && !LEFT_AUX3_MIX_ON && !LEFT_MIC_MIX_ON;
    endproperty
    a_hold_default: assert property (p_hold_default) else $error("mix not held at default");
    property p_aux3_fields;
        take && S_AXI_AWADDR == 8'h18 && S_AXI_WSTRB[1:0] == 2'h3 && !hold ##1 !hold [*3] |->
            LEFT_AUX3_MIX_GAIN == w3[12:8] && RIGHT_AUX3_MIX_GAIN == w3[4:0]
            && LEFT_AUX3_MIX_ON == !(w3[15] || all_mute_reg);
    endproperty
    a_aux3_fields: assert property (p_aux3_fields) else $error("aux3 fields wrong");
    property p_mic_fields;
        take && S_AXI_AWADDR == 8'h1C && S_AXI_WSTRB[1:0] == 2'h3 && !hold ##1 !hold [*3] |->
            LEFT_MIC_MIX_GAIN == w3[12:8] && LEFT_MIC_MIX_ON == !(w3[15] || all_mute_reg);
    endproperty
    a_mic_fields: assert property (p_mic_fields) else $error("mic fields wrong");
    property p_mono_fields;
        take && S_AXI_AWADDR == 8'h20 && S_AXI_WSTRB[1:0] == 2'h3 |->
            ##3 MONO_IN_MIX_GAIN == w3[12:8] && MONO_IN_MIX_ON == !(w3[15] || w3[7]);
    endproperty
    a_mono_fields: assert property (p_mono_fields) else $error("mono fields wrong");
    property p_misc_outputs;
        take && S_AXI_AWADDR == 8'h20 && S_AXI_WSTRB[0] |-> ##3 HEADPHONE_SWING_4V == w3[4]
            && HEADPHONE_OUT_ON == !w3[5] && MONO_OUT_ON == !w3[6] && SUM_PINS_MIX_ON == !(w3[3] || w3[7]);
    endproperty
    a_misc_outputs: assert property (p_misc_outputs) else $error("misc outputs wrong");
    property p_all_mute;
        take && S_AXI_AWADDR == 8'h20 && S_AXI_WSTRB[0] && S_AXI_WDATA[7] |->
            ##3 (!LEFT_AUX3_MIX_ON && !LEFT_MIC_MIX_ON && !SUM_PINS_MIX_ON) [*2];
    endproperty
    a_all_mute: assert property (p_all_mute) else $error("all mix mute not applied");
    property p_reserved_zero;
        S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000 && S_AXI_RDATA[14:13] == 2'h0
            && (ar_reg == 8'h20 ? S_AXI_RDATA[2] == 1'h0 : S_AXI_RDATA[6:5] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
endmodule // mixer_gain_control_regs_checker

// ==== testbench/mixer_gain_control_regs_tb.sv ====
// self-checking bench for the mixer gain register bank
module mixer_gain_control_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TMO = 16;
    logic CORE_CLK = 1'h0, RST = 1'h1, RESET_PIN_N = 1'h1, POWERDOWN_PIN_N = 1'h1;
    logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0, S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
    logic [31:0] S_AXI_WDATA = '0;
    logic [3:0] S_AXI_WSTRB = '0;
    logic DAC1_MIDSCALE_CROSS = '0, DAC2_MIDSCALE_CROSS = '0;
    logic [4:0] DAC1_GAIN_REQ = '0, DAC2_GAIN_REQ = '0;
    wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
    wire [31:0] S_AXI_RDATA;
    wire [4:0] DAC1_GAIN_APPLIED, DAC2_GAIN_APPLIED, LEFT_AUX3_MIX_GAIN, RIGHT_AUX3_MIX_GAIN;
    wire [4:0] LEFT_MIC_MIX_GAIN, RIGHT_MIC_MIX_GAIN, MONO_IN_MIX_GAIN;
    wire LEFT_AUX3_MIX_ON, RIGHT_AUX3_MIX_ON, LEFT_MIC_MIX_ON, RIGHT_MIC_MIX_ON, MONO_IN_MIX_ON;
    wire MONO_OUT_ON, HEADPHONE_OUT_ON, HEADPHONE_SWING_4V, SUM_PINS_MIX_ON;
    int failures = 0, n_checks = 0;
    logic [4:0] g[3] = '{5'h00, 5'h08, 5'h1F};
    logic [15:0] pv[5] = '{16'h0006, 16'h0006, 16'h0007, 16'h0004, 16'h0002};

    mixer_gain_control_regs #(.TIMEOUT_CYCLES(TMO)) mixer_gain_control_regs_i (.*);

    initial forever #2.5 CORE_CLK = ~CORE_CLK;

    task automatic summarize();
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic step(inout int n);
        @(posedge CORE_CLK);
        n++;
        if (n > 100) begin
            failures++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'h1;
        w = 1'h1;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {16'h0000, d};
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        while (aw || w) begin
            step(n);
            if (aw && S_AXI_AWREADY === 1'h1) begin
                aw = 1'h0;
                S_AXI_AWVALID <= 1'h0;
            end
            if (w && S_AXI_WREADY === 1'h1) begin
                w = 1'h0;
                S_AXI_WVALID <= 1'h0;
            end
        end
        S_AXI_BREADY <= 1'h1;
        do step(n); while (S_AXI_BVALID !== 1'h1);
        S_AXI_BREADY <= 1'h0;
        chk("bresp", er, S_AXI_BRESP);
        repeat (3) @(posedge CORE_CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        do step(n); while (S_AXI_ARREADY !== 1'h1);
        S_AXI_ARVALID <= 1'h0;
        S_AXI_RREADY <= 1'h1;
        do step(n); while (S_AXI_RVALID !== 1'h1);
        S_AXI_RREADY <= 1'h0;
        chk("rdata", e, S_AXI_RDATA);
        chk("rresp", er, S_AXI_RRESP);
    endtask

    task automatic t_reset();
        rd(8'h18, 32'h0000_8888, 2'h0);
        rd(8'h1C, 32'h0000_8888, 2'h0);
        rd(8'h20, 32'h0000_8800, 2'h0);
        rd(8'h00, 32'h0000_0006, 2'h0);
    endtask

    task automatic t_fields();
        for (int i = 0; i < 3; i++) begin
            wr(8'h18, {3'h3, g[i], 3'h7, g[i]}, 4'h3, 2'h0);
            rd(8'h18, {19'h0, g[i], 3'h4, g[i]}, 2'h0);
            chk("aux3", {1'h1, g[i], 1'h0, g[i]}, {LEFT_AUX3_MIX_ON, LEFT_AUX3_MIX_GAIN, RIGHT_AUX3_MIX_ON,
                RIGHT_AUX3_MIX_GAIN});
            wr(8'h1C, {3'h4, g[i], 3'h0, g[i]}, 4'h3, 2'h0);
            chk("mic", {1'h0, g[i], 1'h1, g[i]}, {LEFT_MIC_MIX_ON, LEFT_MIC_MIX_GAIN, RIGHT_MIC_MIX_ON,
                RIGHT_MIC_MIX_GAIN});
        end
    endtask

    task automatic t_mono();
        wr(8'h20, 16'hFFFF, 4'h3, 2'h0);
        rd(8'h20, 32'h0000_9FFB, 2'h0);
        chk("misc", {6'h01, 5'h1F}, {MONO_IN_MIX_ON, LEFT_AUX3_MIX_ON, SUM_PINS_MIX_ON, MONO_OUT_ON,
            HEADPHONE_OUT_ON, HEADPHONE_SWING_4V, MONO_IN_MIX_GAIN});
        wr(8'h20, 16'h0410, 4'h3, 2'h0);
        chk("misc", {6'h3F, 5'h04}, {MONO_IN_MIX_ON, LEFT_AUX3_MIX_ON, SUM_PINS_MIX_ON, MONO_OUT_ON,
            HEADPHONE_OUT_ON, HEADPHONE_SWING_4V, MONO_IN_MIX_GAIN});
    endtask

    task automatic t_hold();
        for (int k = 0; k < 5; k++) begin
            wr(8'h18, 16'h0101, 4'h3, 2'h0);
            RESET_PIN_N <= (k != 0);
            POWERDOWN_PIN_N <= (k != 1);
            wr(8'h00, pv[k], 4'h3, 2'h0);
            wr(8'h1C, 16'h0303, 4'h3, 2'h0);
            rd(8'h18, 32'h0000_8888, 2'h0);
            rd(8'h1C, 32'h0000_8888, 2'h0);
            chk("held", {1'h0, 5'h08}, {LEFT_AUX3_MIX_ON, LEFT_AUX3_MIX_GAIN});
            RESET_PIN_N <= 1'h1;
            POWERDOWN_PIN_N <= 1'h1;
            wr(8'h00, 16'h0006, 4'h3, 2'h0);
            rd(8'h18, 32'h0000_8888, 2'h0);
        end
        wr(8'h40, 16'h1234, 4'h3, 2'h2);
        rd(8'h40, 32'h0000_0000, 2'h2);
    endtask

    task automatic t_dac();
        wr(8'h20, 16'h0003, 4'h1, 2'h0);
        DAC1_GAIN_REQ <= 5'h11;
        DAC2_GAIN_REQ <= 5'h12;
        repeat (6) @(posedge CORE_CLK);
        chk("dac", {5'h11, 5'h12}, {DAC1_GAIN_APPLIED, DAC2_GAIN_APPLIED});
        wr(8'h20, 16'h0000, 4'h1, 2'h0);
        DAC1_GAIN_REQ <= 5'h05;
        DAC2_GAIN_REQ <= 5'h07;
        repeat (6) @(posedge CORE_CLK);
        chk("dac", {5'h11, 5'h12}, {DAC1_GAIN_APPLIED, DAC2_GAIN_APPLIED});
        DAC1_MIDSCALE_CROSS <= 1'h1;
        @(posedge CORE_CLK);
        DAC1_MIDSCALE_CROSS <= 1'h0;
        repeat (5) @(posedge CORE_CLK);
        chk("dac", {5'h05, 5'h12}, {DAC1_GAIN_APPLIED, DAC2_GAIN_APPLIED});
        repeat (TMO + 8) @(posedge CORE_CLK);
        chk("dac", {5'h05, 5'h07}, {DAC1_GAIN_APPLIED, DAC2_GAIN_APPLIED});
    endtask

    initial begin
        repeat (20) @(posedge CORE_CLK);
        RST <= 1'h0;
        t_reset();
        t_fields();
        t_mono();
        t_hold();
        t_dac();
        summarize();
    end
endmodule // mixer_gain_control_regs_tb

bind mixer_gain_control_regs mixer_gain_control_regs_checker mixer_gain_control_regs_checker_i (.*);
